// >>> hw/rtc_alarm_pkg.sv
// constants, field layouts and carrier types shared by the alarm and protect logic
package rtc_alarm_pkg;

  // control space byte addresses
  localparam logic [15:0] ADDR_ALARM0_SECONDS = 16'h0000;
  localparam logic [15:0] ADDR_ALARM0_MINUTES = 16'h0001;
  localparam logic [15:0] ADDR_ALARM0_HOURS   = 16'h0002;
  localparam logic [15:0] ADDR_ALARM1_SECONDS = 16'h0008;
  localparam logic [15:0] ADDR_ALARM1_MINUTES = 16'h0009;
  localparam logic [15:0] ADDR_ALARM1_HOURS   = 16'h000A;
  localparam logic [15:0] ADDR_WRITE_PROTECT  = 16'h0010;
  localparam logic [15:0] ADDR_STATUS         = 16'h003F;

  // reset values
  localparam logic [7:0] ALARM_RESET     = 8'h00;
  localparam logic [2:0] PROTECT_DEFAULT = 3'h0;

  // status byte commands and field positions
  localparam logic [7:0] STATUS_CMD_CLEAR      = 8'h00;
  localparam logic [7:0] STATUS_CMD_WRITE      = 8'h02;
  localparam logic [7:0] STATUS_CMD_REG_WRITE  = 8'h06;
  localparam int         STATUS_WRITE_BIT      = 1;
  localparam int         STATUS_REG_WRITE_BIT  = 2;
  localparam int         STATUS_ALARM0_BIT     = 5;
  localparam int         STATUS_ALARM1_BIT     = 6;
  localparam int         ALARM_ENABLE_BIT      = 7;

  // protect codes and segment bounds
  localparam logic [2:0] PROTECT_NONE        = 3'h0;
  localparam logic [2:0] PROTECT_UPPER_QUART = 3'h1;
  localparam logic [2:0] PROTECT_UPPER_HALF  = 3'h2;
  localparam logic [2:0] PROTECT_FULL_LO     = 3'h3;
  localparam logic [2:0] PROTECT_FIRST_4     = 3'h4;
  localparam logic [2:0] PROTECT_FIRST_8     = 3'h5;
  localparam logic [2:0] PROTECT_FIRST_16    = 3'h6;
  localparam logic [2:0] PROTECT_FULL_HI     = 3'h7;
  localparam logic [8:0] BOUND_UPPER_QUART   = 9'h180;
  localparam logic [8:0] BOUND_UPPER_HALF    = 9'h100;
  localparam logic [8:0] LAST_FIRST_4        = 9'h03F;
  localparam logic [8:0] LAST_FIRST_8        = 9'h07F;
  localparam logic [8:0] LAST_FIRST_16       = 9'h0FF;

  // serial bit counter marks
  localparam logic [3:0] BIT_COUNT_ACK  = 4'h8;
  localparam logic [3:0] BIT_COUNT_DONE = 4'h9;

  // one set of time fields, used for both RTC time and alarm settings
  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_fields_t;

endpackage

// >>> hw/alarm_match.sv
// compares one alarm setting against the RTC once per seconds update
`timescale 1ns/1ps
`default_nettype none
module alarm_match
  import rtc_alarm_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst,
  input  wire logic   tick,
  input  wire time_fields_t alarm_set,
  input  wire time_fields_t rtc_time,
  output logic        match
);

  logic en_sec;
  logic en_min;
  logic en_hr;
  logic hit;

  // per-field enables in the top bit; disabled fields always agree
  always_comb
  begin
    en_sec = alarm_set.seconds[ALARM_ENABLE_BIT];
    en_min = alarm_set.minutes[ALARM_ENABLE_BIT];
    en_hr  = alarm_set.hours[ALARM_ENABLE_BIT];
    hit = (!en_sec || alarm_set.seconds[6:0] == rtc_time.seconds[6:0]) &&
          (!en_min || alarm_set.minutes[6:0] == rtc_time.minutes[6:0]) &&
          (!en_hr  || alarm_set.hours[6:0]   == rtc_time.hours[6:0]);
  end

  // evaluated only on the seconds update so a held match fires once
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      match <= 1'b0;
    else
      match <= tick && (en_sec || en_min || en_hr) && hit;
  end

  tick_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    match |-> $past(tick) && !$past(match))
    else $error("alarm match without a seconds update");

  enable_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    match |-> !$past(en_sec) || $past(alarm_set.seconds[6:0]) == $past(rtc_time.seconds[6:0]))
    else $error("alarm match with enabled seconds unequal");

endmodule
`default_nettype wire

// >>> hw/write_protect_check.sv
// decides whether an array address lies in the protected segment
`timescale 1ns/1ps
`default_nettype none
module write_protect_check
  import rtc_alarm_pkg::*;
(
  input  wire logic [2:0] code,
  input  wire logic [8:0] addr,
  output logic            blocked
);

  // segment selection by protect code
  always_comb
  begin
    unique case (code)
      PROTECT_NONE:        blocked = 1'b0;
      PROTECT_UPPER_QUART: blocked = (addr >= BOUND_UPPER_QUART);
      PROTECT_UPPER_HALF:  blocked = (addr >= BOUND_UPPER_HALF);
      PROTECT_FULL_LO:     blocked = 1'b1;
      PROTECT_FIRST_4:     blocked = (addr <= LAST_FIRST_4);
      PROTECT_FIRST_8:     blocked = (addr <= LAST_FIRST_8);
      PROTECT_FIRST_16:    blocked = (addr <= LAST_FIRST_16);
      PROTECT_FULL_HI:     blocked = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// >>> hw/rtc_alarm_protect.sv
// two-wire register slave with alarm registers, status byte and array write filter
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_protect
  import rtc_alarm_pkg::*;
#(
  parameter logic [6:0] CCR_SLAVE   = 7'h6F,
  parameter logic [6:0] ARRAY_SLAVE = 7'h57
)
(
  input  wire logic    ref_clk,
  input  wire logic    rst,
  input  wire logic    scl,
  input  wire logic    sda_in,
  output logic         sda_out,
  output logic         sda_oe,
  input  wire time_fields_t rtc_time,
  input  wire logic    rtc_tick,
  output logic         array_wr,
  output logic [8:0]   array_wr_addr,
  output logic [7:0]   array_wr_data,
  output logic [8:0]   array_rd_addr,
  input  wire logic [7:0] array_rd_data,
  output logic         alarm0_flag,
  output logic         alarm1_flag
);

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_SLAVE   = 6'b000010,
    ST_ADDR_HI = 6'b000100,
    ST_ADDR_LO = 6'b001000,
    ST_WRITE   = 6'b010000,
    ST_READ    = 6'b100000
  } bus_state_t;

  logic         scl_s1;
  logic         scl_s2;
  logic         scl_d;
  logic         sda_s1;
  logic         sda_s2;
  logic         sda_d;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;
  bus_state_t   state;
  logic [3:0]   bit_cnt;
  logic [7:0]   rx;
  logic [7:0]   tx;
  logic [15:0]  addr;
  logic         is_ccr;
  logic         wrote_ccr;
  logic         byte_done;
  logic         wr_strobe;
  logic         ccr_write_ok;
  logic         status_write;
  logic         clr_flags;
  logic [7:0]   read_byte;
  logic [7:0]   status_byte;
  time_fields_t alarm0;
  time_fields_t alarm1;
  logic [2:0]   array_write_protect;
  logic         write_latch;
  logic         register_write_latch;
  logic         match0;
  logic         match1;
  logic         array_blocked;

  // open-drain line: only ever pulled low
  assign sda_out = 1'b0;

  // two-stage synchronisers for the bus pins, plus one delay for edges
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // bus events seen on the synchronised lines
  assign scl_rise  = scl_s2 && !scl_d;
  assign scl_fall  = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop  = scl_s2 && scl_d && !sda_d && sda_s2;
  assign byte_done = scl_fall && (bit_cnt == BIT_COUNT_ACK);

  // write and read decodes at the falling edge of the eighth clock
  assign wr_strobe    = byte_done && (state == ST_WRITE);
  assign ccr_write_ok = wr_strobe && is_ccr && write_latch && register_write_latch;
  assign status_write = wr_strobe && is_ccr && (addr == ADDR_STATUS);
  assign clr_flags    = byte_done && (state == ST_READ) && is_ccr && (addr == ADDR_STATUS);

  // serial state machine: bit counting, ack and read data driving
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx      <= 8'h00;
      tx      <= 8'h00;
      addr    <= 16'h0000;
      is_ccr  <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else if (bus_start)
    begin
      state   <= ST_SLAVE;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end
    else if (bus_stop)
    begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      if (scl_rise && state != ST_IDLE)
      begin
        if (bit_cnt < BIT_COUNT_ACK)
          rx <= {rx[6:0], sda_s2};
        if (state == ST_READ && bit_cnt == BIT_COUNT_ACK && sda_s2)
          state <= ST_IDLE;  // master did not acknowledge: read ends
        if (bit_cnt < BIT_COUNT_DONE)
          bit_cnt <= bit_cnt + 4'h1;
      end
      if (scl_fall)
      begin
        if (bit_cnt == BIT_COUNT_ACK)
        begin
          sda_oe <= 1'b0;
          unique case (state)
            ST_IDLE:
              sda_oe <= 1'b0;
            ST_SLAVE:
              if (rx[7:1] == CCR_SLAVE || rx[7:1] == ARRAY_SLAVE)
              begin
                sda_oe <= 1'b1;
                is_ccr <= (rx[7:1] == CCR_SLAVE);
                state  <= rx[0] ? ST_READ : ST_ADDR_HI;
              end
              else
                state <= ST_IDLE;
            ST_ADDR_HI:
            begin
              addr[15:8] <= rx;
              sda_oe     <= 1'b1;
              state      <= ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
              addr[7:0] <= rx;
              sda_oe    <= 1'b1;
              state     <= ST_WRITE;
            end
            ST_WRITE:
            begin
              sda_oe <= 1'b1;
              addr   <= addr + 16'h0001;
            end
            ST_READ:
              addr <= addr + 16'h0001;
          endcase
        end
        else if (bit_cnt == BIT_COUNT_DONE)
        begin
          bit_cnt <= 4'h0;
          if (state == ST_READ)
          begin
            tx     <= read_byte;
            sda_oe <= !read_byte[7];
          end
          else
            sda_oe <= 1'b0;
        end
        else if (state == ST_READ && bit_cnt != 4'h0)
        begin
          tx     <= {tx[6:0], 1'b0};
          sda_oe <= !tx[6];
        end
      end
    end
  end

  // status byte image
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[STATUS_WRITE_BIT]     = write_latch;
    status_byte[STATUS_REG_WRITE_BIT] = register_write_latch;
    status_byte[STATUS_ALARM0_BIT]    = alarm0_flag;
    status_byte[STATUS_ALARM1_BIT]    = alarm1_flag;
  end

  // read data for the current pointer; unmapped control bytes read zero
  always_comb
  begin
    read_byte = array_rd_data;
    if (is_ccr)
    begin
      unique case (addr)
        ADDR_ALARM0_SECONDS: read_byte = alarm0.seconds;
        ADDR_ALARM0_MINUTES: read_byte = alarm0.minutes;
        ADDR_ALARM0_HOURS:   read_byte = alarm0.hours;
        ADDR_ALARM1_SECONDS: read_byte = alarm1.seconds;
        ADDR_ALARM1_MINUTES: read_byte = alarm1.minutes;
        ADDR_ALARM1_HOURS:   read_byte = alarm1.hours;
        ADDR_WRITE_PROTECT:  read_byte = {5'h00, array_write_protect};
        ADDR_STATUS:         read_byte = status_byte;
        default:             read_byte = 8'h00;
      endcase
    end
  end

  assign array_rd_addr = addr[8:0];

  // persistent alarm and protect registers, changed only under both latches
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      alarm0              <= {3{ALARM_RESET}};
      alarm1              <= {3{ALARM_RESET}};
      array_write_protect <= PROTECT_DEFAULT;
    end
    else if (ccr_write_ok)
    begin
      unique case (addr)
        ADDR_ALARM0_SECONDS: alarm0.seconds <= rx;
        ADDR_ALARM0_MINUTES: alarm0.minutes <= rx;
        ADDR_ALARM0_HOURS:   alarm0.hours   <= rx;
        ADDR_ALARM1_SECONDS: alarm1.seconds <= rx;
        ADDR_ALARM1_MINUTES: alarm1.minutes <= rx;
        ADDR_ALARM1_HOURS:   alarm1.hours   <= rx;
        ADDR_WRITE_PROTECT:  array_write_protect <= rx[2:0];
        default:             array_write_protect <= array_write_protect;
      endcase
    end
  end

  // marks a completed control write in this transfer; start or stop ends it
  always_ff @(posedge ref_clk)
  begin
    if (rst || bus_start || bus_stop)
      wrote_ccr <= 1'b0;
    else if (ccr_write_ok && addr != ADDR_STATUS)
      wrote_ccr <= 1'b1;
  end

  // write latches driven by status byte commands
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      write_latch          <= 1'b0;
      register_write_latch <= 1'b0;
    end
    else if (status_write)
    begin
      if (rx == STATUS_CMD_CLEAR)
      begin
        write_latch          <= 1'b0;
        register_write_latch <= 1'b0;
      end
      else if (rx == STATUS_CMD_WRITE)
        write_latch <= 1'b1;
      else if (rx == STATUS_CMD_REG_WRITE && write_latch)
        register_write_latch <= 1'b1;
    end
    else if (bus_stop && wrote_ccr)
      register_write_latch <= 1'b0;
  end

  // alarm comparators
  alarm_match u_alarm0 (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .tick      (rtc_tick),
    .alarm_set (alarm0),
    .rtc_time  (rtc_time),
    .match     (match0)
  );

  alarm_match u_alarm1 (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .tick      (rtc_tick),
    .alarm_set (alarm1),
    .rtc_time  (rtc_time),
    .match     (match1)
  );

  // sticky alarm flags; a new match wins over the status read clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      alarm0_flag <= 1'b0;
      alarm1_flag <= 1'b0;
    end
    else
    begin
      alarm0_flag <= match0 || (alarm0_flag && !clr_flags);
      alarm1_flag <= match1 || (alarm1_flag && !clr_flags);
    end
  end

  write_protect_check u_protect (
    .code    (array_write_protect),
    .addr    (addr[8:0]),
    .blocked (array_blocked)
  );

  // array write port, filtered by the protect segment
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      array_wr      <= 1'b0;
      array_wr_addr <= 9'h000;
      array_wr_data <= 8'h00;
    end
    else
    begin
      array_wr      <= wr_strobe && !is_ccr && write_latch && !array_blocked;
      array_wr_addr <= addr[8:0];
      array_wr_data <= rx;
    end
  end

  sequence s_ccr_stop;
    wrote_ccr ##0 bus_stop;
  endsequence

  sequence s_blocked_write;
    wr_strobe ##0 (!is_ccr && array_blocked);
  endsequence

  register_write_latch_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_ccr_stop |=> !register_write_latch)
    else $error("register write latch survived a completed control write");

  prot_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_blocked_write |=> !array_wr)
    else $error("write reached a protected array address");

  full_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    (array_write_protect == PROTECT_FULL_LO || array_write_protect == PROTECT_FULL_HI)
      |-> array_blocked)
    else $error("full protect code left an address open");

  no_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    array_write_protect == PROTECT_NONE |-> !array_blocked)
    else $error("protect code zero blocked a write");

  flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    match0 |=> alarm0_flag)
    else $error("alarm0 match did not set its flag");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(alarm1_flag) |-> $past(clr_flags) && !$past(match1))
    else $error("alarm1 flag cleared without a status read");

  alarm_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(alarm0) |-> $past(ccr_write_ok) && $past(register_write_latch))
    else $error("alarm0 changed without an enabled control write");

endmodule
`default_nettype wire

// >>> test/two_wire_host.sv
// two-wire bus master model that reaches the device registers
`timescale 1ns/1ps
`default_nettype none
module two_wire_host
(
  input  wire logic ref_clk,
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_line
);
  // bus idle: clock high, data released to the pull-up
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // half a bus clock period, five reference cycles
  task automatic half();
    repeat (5) @(posedge ref_clk);
  endtask

  // one bit: data set while clock low, line sampled at the end of clock high
  task automatic bit_x(input logic out_v, output logic in_v);
    sda_pull <= ~out_v;
    half();
    scl <= 1'b1;
    half();
    in_v = sda_line;
    scl <= 1'b0;
    @(posedge ref_clk);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
    @(posedge ref_clk);
  endtask

  // stop: data rises while clock is high, then the bus is left idle
  task automatic stop();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask

  // byte out, msb first, ack bit returned
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  // byte in, always answered with a nack (single-byte reads)
  task automatic recv(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      b[i] = s;
    end
    bit_x(1'b1, s);
  endtask

  // write one byte: slave, address high, address low, data
  task automatic wr(input logic [6:0] id, input logic [15:0] a, input logic [7:0] d,
                    output logic ack);
    logic k;
    start();
    send({id, 1'b0}, ack);
    send(a[15:8], k);
    send(a[7:0], k);
    send(d, k);
    stop();
  endtask

  // read one byte: address header, repeated start, slave read, nack
  task automatic rd(input logic [6:0] id, input logic [15:0] a, output logic [7:0] d);
    logic k;
    start();
    send({id, 1'b0}, k);
    send(a[15:8], k);
    send(a[7:0], k);
    start();
    send({id, 1'b1}, k);
    recv(d);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> test/rtc_alarm_match_and_write_protect_tb.sv
// self-checking bench for alarm matching, status flags and array write filter
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_match_and_write_protect_tb;
  import rtc_alarm_pkg::*;
  localparam logic [6:0] CCR_ID = 7'h6F;
  localparam logic [6:0] ARR_ID = 7'h57;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  wire logic    scl;
  wire logic    sda_pull;
  logic         sda_out;
  logic         sda_oe;
  time_fields_t rtc_time = '0;
  logic         rtc_tick = 1'b0;
  logic         array_wr;
  logic [8:0]   array_wr_addr;
  logic [7:0]   array_wr_data;
  logic [8:0]   array_rd_addr;
  logic         alarm0_flag;
  logic         alarm1_flag;
  int           err_total = 0;
  int           cmp_count = 0;
  int           wr_seen = 0;
  logic [8:0]   wr_addr_seen;
  logic [7:0]   wr_data_seen;
  wire logic    sda_line = ~((sda_oe & ~sda_out) | sda_pull);
  wire logic [7:0] array_rd_data = ~array_rd_addr[7:0];

  rtc_alarm_protect #(.CCR_SLAVE(CCR_ID), .ARRAY_SLAVE(ARR_ID)) i_dut
  (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .rtc_time(rtc_time), .rtc_tick(rtc_tick), .array_wr(array_wr),
    .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
    .alarm0_flag(alarm0_flag), .alarm1_flag(alarm1_flag)
  );

  two_wire_host i_host
  (
    .ref_clk(ref_clk), .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line)
  );

  // 125 MHz reference clock
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  // count array write strobes and keep what each one carried
  always @(posedge ref_clk)
  begin
    if (array_wr === 1'b1)
    begin
      wr_seen++;
      wr_addr_seen = array_wr_addr;
      wr_data_seen = array_wr_data;
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    logic k;
    i_host.wr(CCR_ID, a, d, k);
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    i_host.rd(CCR_ID, a, d);
  endtask

  // latch sequence, then one control write
  task automatic set_reg(input logic [15:0] a, input logic [7:0] d);
    reg_wr(ADDR_STATUS, STATUS_CMD_WRITE);
    reg_wr(ADDR_STATUS, STATUS_CMD_REG_WRITE);
    reg_wr(a, d);
  endtask

  // present a time with a one-cycle seconds update, then let the flag settle
  task automatic tick_at(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s);
    @(posedge ref_clk);
    rtc_time <= '{hours: h, minutes: m, seconds: s};
    rtc_tick <= 1'b1;
    @(posedge ref_clk);
    rtc_tick <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic test_reset();
    logic [7:0] d;
    logic       k;
    reg_rd(ADDR_ALARM0_SECONDS, d);
    check8(d, 8'h00, "seconds reset");
    reg_rd(ADDR_ALARM0_MINUTES, d);
    check8(d, 8'h00, "minutes reset");
    reg_rd(ADDR_ALARM0_HOURS, d);
    check8(d, 8'h00, "hours reset");
    reg_rd(ADDR_WRITE_PROTECT, d);
    check8(d, 8'h00, "protect reset");
    reg_rd(16'h0005, d);
    check8(d, 8'h00, "unmapped read");
    i_host.wr(7'h10, 16'h0000, 8'h00, k);
    check1(k, 1'b0, "foreign slave ack");
    $display("test reset done");
  endtask

  task automatic test_latch();
    logic [7:0] d;
    reg_wr(ADDR_ALARM0_SECONDS, 8'h85);
    reg_rd(ADDR_ALARM0_SECONDS, d);
    check8(d, 8'h00, "write without latches");
    set_reg(ADDR_ALARM0_SECONDS, 8'h85);
    reg_rd(ADDR_ALARM0_SECONDS, d);
    check8(d, 8'h85, "seconds written");
    reg_wr(ADDR_ALARM0_MINUTES, 8'h92);
    reg_rd(ADDR_ALARM0_MINUTES, d);
    check8(d, 8'h00, "latch cleared after write");
    set_reg(ADDR_ALARM0_MINUTES, 8'h92);
    reg_rd(ADDR_ALARM0_MINUTES, d);
    check8(d, 8'h92, "minutes written");
    $display("test latch done");
  endtask

  task automatic test_alarm();
    logic [7:0] d;
    tick_at(8'h07, 8'h33, 8'h05);
    check1(alarm0_flag, 1'b0, "one enabled field differs");
    tick_at(8'h07, 8'h12, 8'h05);
    check1(alarm0_flag, 1'b1, "alarm0 match");
    check1(alarm1_flag, 1'b0, "alarm1 idle");
    reg_rd(ADDR_STATUS, d);
    check1(d[STATUS_ALARM0_BIT], 1'b1, "status alarm0 bit");
    check1(alarm0_flag, 1'b0, "flag cleared by read");
    repeat (20) @(posedge ref_clk);
    check1(alarm0_flag, 1'b0, "no retrigger without update");
    set_reg(ADDR_ALARM1_HOURS, 8'h97);
    tick_at(8'h17, 8'h00, 8'h00);
    check1(alarm1_flag, 1'b1, "alarm1 hours match");
    check1(alarm0_flag, 1'b0, "alarm0 stays clear");
    reg_rd(ADDR_STATUS, d);
    check1(d[STATUS_ALARM1_BIT], 1'b1, "status alarm1 bit");
    check1(alarm1_flag, 1'b0, "alarm1 cleared by read");
    $display("test alarm done");
  endtask

  function automatic logic guarded(input logic [2:0] c, input logic [8:0] a);
    case (c)
      3'h1: return a >= 9'h180;
      3'h2: return a >= 9'h100;
      3'h3, 3'h7: return 1'b1;
      3'h4: return a <= 9'h03F;
      3'h5: return a <= 9'h07F;
      3'h6: return a <= 9'h0FF;
      default: return 1'b0;
    endcase
  endfunction

  task automatic test_protect();
    logic [8:0] probes [10] = '{9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF,
                                9'h100, 9'h17F, 9'h180, 9'h1FF};
    logic [7:0] d;
    logic       k;
    int         n;
    for (int c = 0; c < 8; c++)
    begin
      set_reg(ADDR_WRITE_PROTECT, 8'(c));
      reg_rd(ADDR_WRITE_PROTECT, d);
      check8(d & 8'h07, 8'(c), "protect code stored");
      reg_wr(ADDR_STATUS, STATUS_CMD_WRITE);
      foreach (probes[i])
      begin
        n = wr_seen;
        i_host.wr(ARR_ID, {7'h00, probes[i]}, probes[i][7:0] ^ 8'h5A, k);
        check1(wr_seen != n, ~guarded(3'(c), probes[i]), "array write passed");
        if (wr_seen != n)
        begin
          check8(wr_data_seen, probes[i][7:0] ^ 8'h5A, "array data");
          check1(wr_addr_seen == probes[i], 1'b1, "array address");
        end
      end
    end
    i_host.rd(ARR_ID, 16'h01A5, d);
    check8(d, 8'h5A, "array read");
    $display("test protect done");
  endtask

  // watchdog against a hung bus; the scenarios need about 65,000 cycles
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end

  // reset, then the scenarios in turn
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    test_reset();
    test_latch();
    test_alarm();
    test_protect();
    finish_test();
  end
endmodule
`default_nettype wire
